// ### logic/acc_control.v
// actuator network control: node id, nmt state, command pdo, error flags
//
// Operation
// - out-of-range command sets bit 0, blocks motion
// - current over limit 15 ms sets bit 1
// - after overload, enable must drop first
// - voltage fault sets bit 2, 10 s grace
// - temperature fault sets bit 3, 10 s grace
// - uncommanded movement sets bit 4
// - no control message in timeout sets bit 5
// - driven without motion sets bit 6, re-enable
// - memory corruption sets bit 7
// - base 11-bit frames only, 500 kbit/s
// - node id is 19 plus select value
// - nmt slave; control only when operational
// - nmt start to all or matching node
// - control pdo id is 0x200 plus node
// - pdo byte layout: pos, limit, speed, ctrl
// - position unsigned 16-bit, 0.1 mm counts
// - control bit 0 is motion enable
// - no overload check during motor start
// - feedback with error byte every 100 ms
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`default_nettype none
`include "acc_defs.vh"
module acc_control #(
  parameter integer TICK_CYCLES = `ACC_TICK_CYCLES,
  parameter integer GRACE_MS    = `ACC_GRACE_MS,
  parameter integer TIMEOUT_MS  = `ACC_TIMEOUT_MS,
  parameter integer FEEDBACK_MS = `ACC_FEEDBACK_MS
) (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire [2:0]  ADDR_SELECT,
  input  wire        RX_VALID,
  input  wire [10:0] RX_ID,
  input  wire        RX_IDE,
  input  wire [3:0]  RX_DLC,
  input  wire [63:0] RX_DATA,
  input  wire [15:0] MOTOR_CURRENT,
  input  wire        MOTOR_STARTING,
  input  wire        MOTION_SENSED,
  input  wire        UNCOMMANDED_MOVE,
  input  wire        VOLTAGE_OK,
  input  wire        TEMP_OK,
  input  wire        MEMORY_BAD,
  output reg         MOTION_RUN,
  output reg  [15:0] TARGET_POSITION,
  output reg  [15:0] CURRENT_LIMIT,
  output reg  [7:0]  TARGET_SPEED,
  output reg  [7:0]  ERROR_FLAGS,
  output reg  [6:0]  NODE_ID,
  output reg         OPERATIONAL,
  output reg         FEEDBACK_REQ,
  input  wire [7:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST
);
  // --------------------------------------------------------------------------
  // nmt states
  // --------------------------------------------------------------------------
  localparam [1:0] ST_INIT = 2'd0;
  localparam [1:0] ST_PREOP = 2'd1;
  localparam [1:0] ST_OPER = 2'd2;
  localparam [1:0] ST_STOP = 2'd3;

  wire        tick;
  reg  [1:0]  nmt_state;
  reg         id_taken;
  reg         enable_prev;
  reg         need_reenable;
  reg         ctrl_force_stop;
  reg  [15:0] timeout_ms;
  reg  [15:0] max_limit;
  reg  [15:0] frame_count;
  reg         pdo_seen;
  reg  [7:0]  next_errors;
  reg  [31:0] rd_data;
  reg         ack;

  // --------------------------------------------------------------------------
  // frame classification
  // --------------------------------------------------------------------------
  wire base_frame = RX_VALID && !RX_IDE;
  wire is_nmt  = base_frame && RX_ID == `ACC_NMT_ID && RX_DLC >= 4'd2;
  wire nmt_hit = RX_DATA[15:8] == `ACC_NMT_ALL ||
                 RX_DATA[15:8] == {1'b0, NODE_ID};
  wire is_pdo  = base_frame && id_taken && RX_DLC == 4'd8 &&
                 RX_ID == `ACC_RPDO_BASE + {4'h0, NODE_ID};
  wire pdo_ok  = is_pdo && nmt_state == ST_OPER;
  wire [15:0] rx_pos   = {RX_DATA[15:8], RX_DATA[7:0]};
  wire [15:0] rx_lim   = {RX_DATA[31:24], RX_DATA[23:16]};
  wire [7:0]  rx_speed = RX_DATA[39:32];
  wire        rx_en    = RX_DATA[56 + `ACC_CTRL_ENABLE];
  // a zero limit would trip immediately, so it is treated as out of range
  wire rx_bad = rx_lim > max_limit || rx_lim == 16'h0000;

  // --------------------------------------------------------------------------
  // timers
  // --------------------------------------------------------------------------
  wire over_ms;
  wire volt_grace_end;
  wire temp_grace_end;
  wire msg_timeout;
  wire fb_due;
  acc_tick #(.DIV(TICK_CYCLES)) u_tick (
    .clk    (CLK),
    .resetn (RESETN),
    .tick   (tick)
  );
  acc_mstimer #(.W(16)) u_over (
    .clk     (CLK),
    .resetn  (RESETN),
    .tick    (tick),
    .run     (MOTION_RUN && !MOTOR_STARTING && MOTOR_CURRENT > CURRENT_LIMIT),
    .limit   (16'd`ACC_OVERLOAD_MS),
    .expired (over_ms)
  );
  acc_mstimer #(.W(16)) u_volt (
    .clk     (CLK),
    .resetn  (RESETN),
    .tick    (tick),
    .run     (!VOLTAGE_OK && MOTION_RUN),
    .limit   (GRACE_MS[15:0]),
    .expired (volt_grace_end)
  );
  acc_mstimer #(.W(16)) u_temp (
    .clk     (CLK),
    .resetn  (RESETN),
    .tick    (tick),
    .run     (!TEMP_OK && MOTION_RUN),
    .limit   (GRACE_MS[15:0]),
    .expired (temp_grace_end)
  );
  acc_mstimer #(.W(16)) u_msg (
    .clk     (CLK),
    .resetn  (RESETN),
    .tick    (tick),
    .run     (nmt_state == ST_OPER && !pdo_ok),
    .limit   (timeout_ms),
    .expired (msg_timeout)
  );
  acc_mstimer #(.W(16)) u_fb (
    .clk     (CLK),
    .resetn  (RESETN),
    .tick    (tick),
    .run     (!FEEDBACK_REQ),
    .limit   (FEEDBACK_MS[15:0]),
    .expired (fb_due)
  );

  // --------------------------------------------------------------------------
  // node id and nmt state
  // --------------------------------------------------------------------------
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      NODE_ID   <= `ACC_NODE_BASE;
      id_taken  <= 1'b0;
      nmt_state <= ST_INIT;
    end else begin
      if (!id_taken) begin
        NODE_ID  <= `ACC_NODE_BASE + {4'h0, ADDR_SELECT};
        id_taken <= 1'b1;
      end
      case (nmt_state)
        ST_INIT: begin
          if (id_taken)
            nmt_state <= ST_PREOP;
        end
        default: begin
          if (is_nmt && nmt_hit) begin
            case (RX_DATA[7:0])
              `ACC_NMT_START: nmt_state <= ST_OPER;
              `ACC_NMT_STOP:  nmt_state <= ST_STOP;
              `ACC_NMT_PREOP: nmt_state <= ST_PREOP;
              default:        nmt_state <= nmt_state;
            endcase
          end
        end
      endcase
    end
  end

  always @* begin
    OPERATIONAL = (nmt_state == ST_OPER);
  end

  // --------------------------------------------------------------------------
  // command capture and motion gate
  // --------------------------------------------------------------------------
  wire start_block = ERROR_FLAGS[`ACC_ERR_PARAM] || !VOLTAGE_OK || !TEMP_OK ||
                     need_reenable || ctrl_force_stop;
  wire trip = over_ms || (MOTION_RUN && !MOTOR_STARTING && !MOTION_SENSED);
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      TARGET_POSITION <= 16'h0000;
      CURRENT_LIMIT   <= 16'h0000;
      TARGET_SPEED    <= 8'h00;
      enable_prev     <= 1'b0;
      need_reenable   <= 1'b0;
      MOTION_RUN      <= 1'b0;
      pdo_seen        <= 1'b0;
    end else begin
      if (pdo_ok && !rx_bad) begin
        TARGET_POSITION <= rx_pos;
        CURRENT_LIMIT   <= rx_lim;
        TARGET_SPEED    <= rx_speed;
      end
      if (pdo_ok) begin
        enable_prev <= rx_en;
        pdo_seen    <= 1'b1;
      end
      // trip wins over a same-cycle enable drop
      if (trip)
        need_reenable <= 1'b1;
      else if (pdo_ok && !rx_en)
        need_reenable <= 1'b0;
      if (trip || ERROR_FLAGS[`ACC_ERR_PARAM] || volt_grace_end || temp_grace_end ||
          nmt_state != ST_OPER || ctrl_force_stop || (pdo_ok && (!rx_en || rx_bad)))
        MOTION_RUN <= 1'b0;
      else if (pdo_ok && rx_en && !rx_bad && !start_block)
        MOTION_RUN <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // error flags, feedback pacing
  // --------------------------------------------------------------------------
  always @* begin
    next_errors = ERROR_FLAGS;
    // voltage and temp clear once back in range; timeout clears on any pdo, param on an in-range pdo, overload and fatal on a pdo with enable off
    if (VOLTAGE_OK)
      next_errors[`ACC_ERR_VOLTAGE] = 1'b0;
    if (TEMP_OK)
      next_errors[`ACC_ERR_TEMP] = 1'b0;
    if (pdo_ok)
      next_errors[`ACC_ERR_TIMEOUT] = 1'b0;
    if (pdo_ok && !rx_bad)
      next_errors[`ACC_ERR_PARAM] = 1'b0;
    if (pdo_ok && !rx_en) begin
      next_errors[`ACC_ERR_OVERLOAD] = 1'b0;
      next_errors[`ACC_ERR_FATAL]    = 1'b0;
    end
    // sets come last so they win over a clear
    if (pdo_ok && rx_bad)
      next_errors[`ACC_ERR_PARAM] = 1'b1;
    if (over_ms)
      next_errors[`ACC_ERR_OVERLOAD] = 1'b1;
    if (!VOLTAGE_OK)
      next_errors[`ACC_ERR_VOLTAGE] = 1'b1;
    if (!TEMP_OK)
      next_errors[`ACC_ERR_TEMP] = 1'b1;
    if (UNCOMMANDED_MOVE && !MOTION_RUN)
      next_errors[`ACC_ERR_BACKDRIVE] = 1'b1;
    if (msg_timeout)
      next_errors[`ACC_ERR_TIMEOUT] = 1'b1;
    if (MOTION_RUN && !MOTOR_STARTING && !MOTION_SENSED)
      next_errors[`ACC_ERR_FATAL] = 1'b1;
    if (MEMORY_BAD)
      next_errors[`ACC_ERR_MEMORY] = 1'b1;
  end

  wire sw_clear = ack && AVS_WRITE && AVS_ADDRESS == `ACC_REG_ERRFLAGS && AVS_BYTEENABLE[0];
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ERROR_FLAGS  <= 8'h00;
      FEEDBACK_REQ <= 1'b0;
    end else begin
      // software may clear only backdrive and memory; a live set still wins
      if (sw_clear)
        ERROR_FLAGS <= next_errors & ~(AVS_WRITEDATA[7:0] & 8'h90 & ~(
                       {MEMORY_BAD, 2'b00, UNCOMMANDED_MOVE && !MOTION_RUN, 4'h0}));
      else
        ERROR_FLAGS <= next_errors;
      FEEDBACK_REQ <= fb_due;
    end
  end

  // --------------------------------------------------------------------------
  // avalon-mm slave, one wait state per access
  // --------------------------------------------------------------------------
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
  wire wr = ack && AVS_WRITE;
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack             <= 1'b0;
      AVS_READDATA    <= 32'h0;
      ctrl_force_stop <= 1'b0;
      timeout_ms      <= TIMEOUT_MS[15:0];
      max_limit       <= `ACC_CURLIM_MAX_RST;
      frame_count     <= 16'h0000;
    end else begin
      ack <= (AVS_READ || AVS_WRITE) && !ack;
      if (AVS_READ && !ack)
        AVS_READDATA <= rd_data;
      if (pdo_ok)
        frame_count <= frame_count + 16'h0001;
      if (wr && AVS_ADDRESS == `ACC_REG_CTRL && AVS_BYTEENABLE[0])
        ctrl_force_stop <= AVS_WRITEDATA[0];
      if (wr && AVS_ADDRESS == `ACC_REG_TIMEOUT && AVS_BYTEENABLE[1:0] == 2'b11)
        timeout_ms <= AVS_WRITEDATA[15:0];
      if (wr && AVS_ADDRESS == `ACC_REG_MAXLIM && AVS_BYTEENABLE[1:0] == 2'b11)
        max_limit <= AVS_WRITEDATA[15:0];
    end
  end

  always @* begin
    case (AVS_ADDRESS)
      `ACC_REG_CTRL:     rd_data = {31'h0, ctrl_force_stop};
      `ACC_REG_STATUS:   rd_data = {26'h0, pdo_seen, need_reenable, enable_prev,
                                    MOTION_RUN, nmt_state};
      `ACC_REG_ERRFLAGS: rd_data = {24'h0, ERROR_FLAGS};
      `ACC_REG_NODEID:   rd_data = {25'h0, NODE_ID};
      `ACC_REG_POSITION: rd_data = {16'h0, TARGET_POSITION};
      `ACC_REG_CURLIM:   rd_data = {16'h0, CURRENT_LIMIT};
      `ACC_REG_SPEED:    rd_data = {24'h0, TARGET_SPEED};
      `ACC_REG_TIMEOUT:  rd_data = {16'h0, timeout_ms};
      `ACC_REG_MAXLIM:   rd_data = {16'h0, max_limit};
      `ACC_REG_FRAMES:   rd_data = {16'h0, frame_count};
      default:           rd_data = 32'h0;
    endcase
  end
endmodule // acc_control
`default_nettype wire

// ### include/acc_defs.vh
// constants for the actuator network control and status block
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ACC_REG_CTRL      8'h00
`define ACC_REG_STATUS    8'h04
`define ACC_REG_ERRFLAGS  8'h08
`define ACC_REG_NODEID    8'h0C
`define ACC_REG_POSITION  8'h10
`define ACC_REG_CURLIM    8'h14
`define ACC_REG_SPEED     8'h18
`define ACC_REG_TIMEOUT   8'h1C
`define ACC_REG_MAXLIM    8'h20
`define ACC_REG_FRAMES    8'h24
// ----------------------------------------------------------------------------
// error flag bit positions
// ----------------------------------------------------------------------------
`define ACC_ERR_PARAM     0
`define ACC_ERR_OVERLOAD  1
`define ACC_ERR_VOLTAGE   2
`define ACC_ERR_TEMP      3
`define ACC_ERR_BACKDRIVE 4
`define ACC_ERR_TIMEOUT   5
`define ACC_ERR_FATAL     6
`define ACC_ERR_MEMORY    7
// ----------------------------------------------------------------------------
// frame identifiers and payload fields
// ----------------------------------------------------------------------------
`define ACC_NODE_BASE     7'h13
`define ACC_NMT_ID        11'h000
`define ACC_NMT_START     8'h01
`define ACC_NMT_STOP      8'h02
`define ACC_NMT_PREOP     8'h80
`define ACC_NMT_ALL       8'h00
`define ACC_RPDO_BASE     11'h200
`define ACC_CTRL_ENABLE   0
// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define ACC_CURLIM_MAX_RST 16'h0082
`define ACC_CLK_HZ        100000000
`define ACC_TICK_US       1000
`define ACC_TICK_CYCLES   (`ACC_CLK_HZ / 1000000 * `ACC_TICK_US)
`define ACC_OVERLOAD_MS   15
`define ACC_GRACE_MS      10000
`define ACC_TIMEOUT_MS    5000
`define ACC_FEEDBACK_MS   100
`define ACC_BITRATE_BPS   500000
`endif

// ### logic/acc_tick.v
// millisecond enable pulse divider
`default_nettype none
`include "acc_defs.vh"
module acc_tick #(
  parameter integer DIV = `ACC_TICK_CYCLES
) (
  input  wire clk,
  input  wire resetn,
  output reg  tick
);
  reg [31:0] count;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count == DIV - 1) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule // acc_tick
`default_nettype wire

// ### logic/acc_mstimer.v
// millisecond up-counter that restarts on demand and flags expiry
`default_nettype none
module acc_mstimer #(
  parameter integer W = 16
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire         tick,
  input  wire         run,
  input  wire [W-1:0] limit,
  output wire         expired
);
  reg [W-1:0] count;
  // counting stops at the limit so expiry stays a level
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= {W{1'b0}};
    end else if (!run) begin
      count <= {W{1'b0}};
    end else if (tick && count < limit) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign expired = run && (count >= limit);
endmodule // acc_mstimer
`default_nettype wire

// ### verif/acc_host_model.sv
// bus master model that hands decoded frames to the block
`default_nettype none
module acc_host_model (
  input  wire logic        CLK,
  input  wire logic        SEND,
  input  wire logic [10:0] ID,
  input  wire logic        EXT,
  input  wire logic [63:0] DATA,
  output var  logic        RX_VALID,
  output var  logic [10:0] RX_ID,
  output var  logic        RX_IDE,
  output var  logic [3:0]  RX_DLC,
  output var  logic [63:0] RX_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    RX_VALID = 1'b0;
    RX_DATA  = 64'h0;
  end
  // payload toggles between frames: stale data must never look valid
  always @(posedge CLK) begin
    RX_VALID <= SEND;
    if (SEND) begin
      RX_ID   <= ID;
      RX_IDE  <= EXT;
      RX_DLC  <= (ID == 11'h000) ? 4'h2 : 4'h8;
      RX_DATA <= DATA;
    end else begin
      RX_DATA <= ~RX_DATA;
    end
  end
endmodule // acc_host_model
`default_nettype wire

// ### verif/acc_control_monitor.sv
// assertion checker bound to the network control block
`default_nettype none
module acc_control_monitor #(
  parameter integer TICK_CYCLES = 10,
  parameter integer FEEDBACK_MS = 100
) (
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       MOTOR_STARTING,
  input wire logic       MOTION_SENSED,
  input wire logic       UNCOMMANDED_MOVE,
  input wire logic       VOLTAGE_OK,
  input wire logic       TEMP_OK,
  input wire logic       MEMORY_BAD,
  input wire logic       MOTION_RUN,
  input wire logic [7:0] ERROR_FLAGS,
  input wire logic [6:0] NODE_ID,
  input wire logic       FEEDBACK_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer P = FEEDBACK_MS * TICK_CYCLES;
  logic [1:0]  rcnt;
  logic [31:0] fcnt;
  logic        fseen;
  // ----
  // helper counters
  // ----
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rcnt  <= 2'h0;
      fcnt  <= 32'h0;
      fseen <= 1'b0;
    end else begin
      rcnt  <= (rcnt == 2'h3) ? rcnt : rcnt + 2'h1;
      fcnt  <= FEEDBACK_REQ ? 32'h1 : fcnt + 32'h1;
      fseen <= fseen | FEEDBACK_REQ;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  node_fixed_a: assert property (
    rcnt >= 2'h2 |-> $stable(NODE_ID)) else $error("node id moved");
  param_block_a: assert property (
    ERROR_FLAGS[0] |-> !MOTION_RUN) else $error("run with bad param");
  start_clean_a: assert property (
    $rose(MOTION_RUN) |-> (ERROR_FLAGS & 8'h4F) == 8'h00) else $error("run under fault");
  volt_flag_a: assert property (
    !VOLTAGE_OK |=> ERROR_FLAGS[2]) else $error("voltage flag missing");
  temp_flag_a: assert property (
    !TEMP_OK |=> ERROR_FLAGS[3]) else $error("temp flag missing");
  back_flag_a: assert property (
    UNCOMMANDED_MOVE |=> ERROR_FLAGS[4]) else $error("backdrive flag missing");
  fatal_flag_a: assert property (
    MOTION_RUN && !MOTOR_STARTING && !MOTION_SENSED |=> ERROR_FLAGS[6])
    else $error("fatal flag missing");
  mem_flag_a: assert property (
    MEMORY_BAD |=> ERROR_FLAGS[7]) else $error("memory flag missing");
  feed_period_a: assert property (
    FEEDBACK_REQ && fseen |-> fcnt == P || fcnt == P + 1) else $error("feedback period off");
endmodule // acc_control_monitor
bind acc_control acc_control_monitor #(
  .TICK_CYCLES(TICK_CYCLES),
  .FEEDBACK_MS(FEEDBACK_MS)
) u_acc_control_monitor (
  .CLK(CLK), .RESETN(RESETN), .MOTOR_STARTING(MOTOR_STARTING),
  .MOTION_SENSED(MOTION_SENSED), .UNCOMMANDED_MOVE(UNCOMMANDED_MOVE),
  .VOLTAGE_OK(VOLTAGE_OK), .TEMP_OK(TEMP_OK), .MEMORY_BAD(MEMORY_BAD),
  .MOTION_RUN(MOTION_RUN), .ERROR_FLAGS(ERROR_FLAGS), .NODE_ID(NODE_ID),
  .FEEDBACK_REQ(FEEDBACK_REQ)
);
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the network control block
`default_nettype none
`include "acc_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer MS = 10;  // cycles per ms with the shortened tick
  localparam integer TO = 100;
  logic        CLK = 1'b0, RESETN = 1'b0, snd = 1'b0, side = 1'b0;
  logic [2:0]  ADDR_SELECT = 3'h0;
  logic [10:0] sid = 11'h0, pid, RX_ID;
  logic [63:0] sdat = 64'h0, RX_DATA;
  logic        RX_VALID, RX_IDE, MOTION_RUN, FEEDBACK_REQ, AVS_WAITREQUEST, OPERATIONAL;
  logic [3:0]  RX_DLC;
  logic [15:0] MOTOR_CURRENT = 16'h0, TARGET_POSITION, CURRENT_LIMIT, pos, lim, glim;
  logic        MOTOR_STARTING = 1'b0, MOTION_SENSED = 1'b1, UNCOMMANDED_MOVE = 1'b0;
  logic        VOLTAGE_OK = 1'b1, TEMP_OK = 1'b1, MEMORY_BAD = 1'b0;
  logic [7:0]  TARGET_SPEED, ERROR_FLAGS, spd, AVS_ADDRESS = 8'h0;
  logic [6:0]  NODE_ID, nid;
  logic        AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
  int          err_count = 0, n_compared = 0, cyc = 0, fb_n = 0, fb0;
  acc_control #(.TICK_CYCLES(MS), .GRACE_MS(20), .TIMEOUT_MS(TO), .FEEDBACK_MS(10))
  u_acc_control (.CLK, .RESETN, .ADDR_SELECT, .RX_VALID, .RX_ID, .RX_IDE, .RX_DLC,
    .RX_DATA, .MOTOR_CURRENT, .MOTOR_STARTING, .MOTION_SENSED, .UNCOMMANDED_MOVE,
    .VOLTAGE_OK, .TEMP_OK, .MEMORY_BAD, .MOTION_RUN, .TARGET_POSITION, .CURRENT_LIMIT,
    .TARGET_SPEED, .ERROR_FLAGS, .NODE_ID, .OPERATIONAL, .FEEDBACK_REQ, .AVS_ADDRESS,
    .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hF), .AVS_READDATA,
    .AVS_WAITREQUEST);
  acc_host_model u_acc_host_model (.CLK, .SEND(snd), .ID(sid), .EXT(side), .DATA(sdat),
    .RX_VALID, .RX_ID, .RX_IDE, .RX_DLC, .RX_DATA);
  // ----
  // helpers
  // ----
  initial forever #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (FEEDBACK_REQ)
      fb_n <= fb_n + 1;
    if (cyc == 10000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic frm(input logic [10:0] i, input logic [63:0] d, input logic e = 1'b0);
    @(posedge CLK);
    snd <= 1'b1;
    sid <= i;
    side <= e;
    sdat <= d;
    @(posedge CLK);
    snd <= 1'b0;
    wt(3);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  function automatic logic [63:0] pdo(input logic en);
    return {7'h0, en, 16'h0, spd, lim, pos};
  endfunction
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(13));
    nid = `ACC_NODE_BASE + 7'($urandom % 8);
    ADDR_SELECT <= 3'(nid - `ACC_NODE_BASE);
    pid = `ACC_RPDO_BASE + 11'(nid);
    pos = 16'($urandom);
    spd = 8'($urandom);
    glim = 16'h1 + 16'($urandom % 130);
    lim = glim;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    wt(3);
    chk("node", nid, NODE_ID);
    ADDR_SELECT <= ~ADDR_SELECT;
    bus(1'b0, `ACC_REG_NODEID, 32'h0);
    chk("node reg", nid, rd);
    bus(1'b0, `ACC_REG_TIMEOUT, 32'h0);
    chk("timeout reg", TO, rd);
    bus(1'b1, 8'h30, 32'hFFFF);
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped", 0, rd);
    frm(pid, pdo(1'b1));
    chk("run preop", 0, MOTION_RUN);
    frm(`ACC_NMT_ID, {48'h0, 1'b0, (nid == 7'h1A) ? 7'h13 : nid + 7'h1, `ACC_NMT_START});
    bus(1'b0, `ACC_REG_STATUS, 32'h0);
    chk("other node", 0, rd[1:0] === 2'h2);
    frm(`ACC_NMT_ID, {48'h0, `ACC_NMT_ALL, `ACC_NMT_START});
    bus(1'b0, `ACC_REG_STATUS, 32'h0);
    chk("state", 2, rd[1:0]);
    chk("operational", 1, OPERATIONAL);
    frm(pid, pdo(1'b1), 1'b1);
    chk("run ext", 0, MOTION_RUN);
    frm(pid + 11'h1, pdo(1'b1));
    chk("run other id", 0, MOTION_RUN);
    frm(pid, pdo(1'b1));
    chk("pos", pos, TARGET_POSITION);
    chk("limit", lim, CURRENT_LIMIT);
    chk("speed", spd, TARGET_SPEED);
    chk("run", 1, MOTION_RUN);
    MOTOR_STARTING <= 1'b1;
    MOTOR_CURRENT <= lim + 16'h1;
    wt(20 * MS);
    chk("inrush", 0, ERROR_FLAGS[1]);
    MOTOR_STARTING <= 1'b0;
    wt(12 * MS);
    chk("over early", 0, ERROR_FLAGS[1]);
    wt(6 * MS);
    chk("over", 1, ERROR_FLAGS[1]);
    chk("run over", 0, MOTION_RUN);
    MOTOR_CURRENT <= 16'h0;
    frm(pid, pdo(1'b1));
    chk("no restart", 0, MOTION_RUN);
    frm(pid, pdo(1'b0));
    frm(pid, pdo(1'b1));
    chk("restart", 1, MOTION_RUN);
    for (int i = 0; i < 2; i++) begin
      lim = i ? 16'h83 : 16'h0;  // both edges just outside the range
      frm(pid, pdo(1'b1));
      chk("param", 1, ERROR_FLAGS[0]);
      chk("run param", 0, MOTION_RUN);
    end
    lim = glim;
    frm(pid, pdo(1'b0));
    frm(pid, pdo(1'b1));
    for (int i = 0; i < 2; i++) begin
      {TEMP_OK, VOLTAGE_OK} <= i ? 2'b01 : 2'b10;
      wt(15 * MS);
      chk("fault flag", 1, ERROR_FLAGS[2 + i]);
      chk("grace", 1, MOTION_RUN);
      wt(10 * MS);
      chk("grace end", 0, MOTION_RUN);
      frm(pid, pdo(1'b0));
      frm(pid, pdo(1'b1));
      chk("refused", 0, MOTION_RUN);
      {TEMP_OK, VOLTAGE_OK} <= 2'b11;
      frm(pid, pdo(1'b0));
      frm(pid, pdo(1'b1));
      chk("resumed", 1, MOTION_RUN);
    end
    fb0 = fb_n;
    wt(70 * MS);
    chk("feedback", 7, fb_n - fb0);
    frm(pid, pdo(1'b1));
    wt(70 * MS);
    chk("timeout early", 0, ERROR_FLAGS[5]);
    wt(40 * MS);
    chk("timeout", 1, ERROR_FLAGS[5]);
    frm(pid, pdo(1'b0));
    frm(pid, pdo(1'b1));
    MOTION_SENSED <= 1'b0;
    wt(2);
    chk("fatal", 1, ERROR_FLAGS[6]);
    chk("run fatal", 0, MOTION_RUN);
    MOTION_SENSED <= 1'b1;
    {MEMORY_BAD, UNCOMMANDED_MOVE} <= 2'b11;
    wt(1);
    {MEMORY_BAD, UNCOMMANDED_MOVE} <= 2'b00;
    wt(2);
    chk("memory", 1, ERROR_FLAGS[7]);
    chk("backdrive", 1, ERROR_FLAGS[4]);
    bus(1'b1, `ACC_REG_ERRFLAGS, 32'h90);
    bus(1'b0, `ACC_REG_ERRFLAGS, 32'h0);
    chk("flag clear", 0, rd[7:0] & 8'h90);
    frm(pid, pdo(1'b0));
    frm(`ACC_NMT_ID, {48'h0, 1'b0, nid, `ACC_NMT_STOP});
    chk("stopped", 0, OPERATIONAL);
    frm(pid, pdo(1'b1));
    chk("run stopped", 0, MOTION_RUN);
    frm(`ACC_NMT_ID, {48'h0, 1'b0, nid, `ACC_NMT_START});
    chk("own node", 1, OPERATIONAL);
    frm(pid, pdo(1'b1));
    chk("run own node", 1, MOTION_RUN);
    summarize();
  end
endmodule // tb
`default_nettype wire
